// ---- dv/hc_regs_sva.sv ----
/* checker for the revision/control register pair.
   assumes the design's port names and its one-cycle register port. */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// port level checks
// ----------------------------------------
module hc_regs_sva (
   // clock and resets
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic soft_rst_i,
   // register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic reg_ack_o,
   // events and outputs
   input wire logic resume_detected_i,
   input wire logic event_irq_i,
   input wire logic [1:0] functional_state_o,
   input wire logic remote_wakeup_o,
   input wire logic host_irq_o,
   input wire logic mgmt_irq_o,
   input wire logic sof_enable_o,
   input wire logic ple_o,
   input wire logic cle_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // list bits may move only two or three edges after a write or soft reset
   a_ack_follows: assert property ((reg_rd_i || reg_wr_i) |=> reg_ack_o)
      else $error("access not acknowledged");
   a_rev_value: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
      reg_rdata_o == 32'h0000_0010) else $error("revision value wrong");
   a_rdata_quiet: assert property (!reg_ack_o |-> reg_rdata_o == 32'h0)
      else $error("read data outside ack");
   a_wakeup_cause: assert property (remote_wakeup_o |->
      $past(resume_detected_i)) else $error("wakeup without resume");
   a_irq_route: assert property (!$past(sys_rst_i) |->
      (host_irq_o || mgmt_irq_o) == $past(event_irq_i))
      else $error("event interrupt lost");
   a_irq_exclusive: assert property (!(host_irq_o && mgmt_irq_o))
      else $error("both interrupt outputs high");
   a_list_hold: assert property ($changed(ple_o) || $changed(cle_o) |->
      $past(reg_wr_i, 2) || $past(reg_wr_i, 3) || $past(soft_rst_i, 2) ||
      $past(soft_rst_i, 3)) else $error("list bit changed on its own");
   a_soft_suspend: assert property (soft_rst_i |->
      ##[1:3] functional_state_o == 2'h3) else $error("no suspend");
   a_hw_reset_clear: assert property ($fell(sys_rst_i) |->
      functional_state_o == 2'h0 && !sof_enable_o) else $error("bad reset");
   a_sof_operational: assert property ($rose(sof_enable_o) |->
      functional_state_o == 2'h2) else $error("frame start off state");
   c_mgmt: cover property (mgmt_irq_o);
   c_wakeup: cover property (remote_wakeup_o);
   c_sof: cover property ($rose(sof_enable_o));
endmodule // hc_regs_sva
bind hc_revision_control_regs hc_regs_sva u_sva (.core_clk_i, .sys_rst_i,
   .soft_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_ack_o,
   .resume_detected_i, .event_irq_i, .functional_state_o, .remote_wakeup_o,
   .host_irq_o, .mgmt_irq_o, .sof_enable_o, .ple_o, .cle_o);
`default_nettype wire

// ---- dv/tb_hc_revision_control_regs.sv ----
/* self-checking bench for the revision/control register pair.
   assumes inputs change on falling edges and a short frame-start delay. */
`timescale 1ns/1ps
`default_nettype none
module tb_hc_revision_control_regs;
   logic core_clk_i = 1'b0, sys_rst_i = 1'b1, soft_rst_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   logic [3:0] reg_be_i = 4'h0;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
   logic resume_detected_i = 1'b0, event_irq_i = 1'b0;
   logic downstream_resume_i = 1'b0;
   logic reg_ack_o, remote_wakeup_o, host_irq_o, mgmt_irq_o, sof_enable_o;
   logic ple_o, ie_o, cle_o, ble_o;
   logic [1:0] functional_state_o, cbsr_o;
   int error_cnt = 0, n_tests = 0;
   always #4 core_clk_i = ~core_clk_i;
   // short delay keeps the run brief; expectations scale with it
   hc_revision_control_regs #(.sof_delay(20)) dut (.core_clk_i, .sys_rst_i,
      .soft_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_be_i, .reg_wdata_i,
      .reg_rdata_o, .reg_ack_o, .resume_detected_i, .event_irq_i,
      .downstream_resume_i, .functional_state_o, .remote_wakeup_o,
      .host_irq_o, .mgmt_irq_o, .sof_enable_o, .ple_o, .ie_o, .cle_o,
      .ble_o, .cbsr_o);
   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // strobe for one edge, then look at ack in the cycle it stands
   task automatic acc(input logic wr, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] d);
      @(negedge core_clk_i);
      reg_wr_i = wr;
      reg_rd_i = !wr;
      reg_addr_i = a;
      reg_be_i = be;
      reg_wdata_i = d;
      @(negedge core_clk_i);
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      chk(32'(reg_ack_o), 32'h1);
   endtask
   task automatic wr(input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
      acc(1'b1, a, be, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'b0, a, 4'h0, 32'h0);
      chk(reg_rdata_o, exp);
   endtask
   task automatic stop_test;
      $display("checks %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // watchdog: the sequence needs well under 2000 cycles
   initial begin
      #50000;
      error_cnt++;
      stop_test;
   end
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      int k;
      repeat (6) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      rd(8'h00, 32'h0000_0010);
      wr(8'h00, 4'hf, 32'hffff_ffff);
      rd(8'h00, 32'h0000_0010);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      $display("test reset_values done");
      wr(8'h04, 4'hf, 32'h0000_07fc);
      rd(8'h04, 32'h0000_07fc);
      chk(32'({ble_o, cle_o, ie_o, ple_o, cbsr_o}), 32'h3c);
      event_irq_i = 1'b1;
      resume_detected_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      chk(32'({host_irq_o, mgmt_irq_o, remote_wakeup_o}), 32'h3);
      wr(8'h04, 4'h2, 32'h0000_0200);
      repeat (2) @(negedge core_clk_i);
      chk(32'({host_irq_o, mgmt_irq_o, remote_wakeup_o}), 32'h4);
      // wakeup enable sets and wakeup-connected clears: interrupt routing must not follow them
      wr(8'h04, 4'h2, 32'h0000_0400);
      repeat (2) @(negedge core_clk_i);
      chk(32'({host_irq_o, mgmt_irq_o, remote_wakeup_o}), 32'h5);
      // leave suspend so the software reset has a state to change
      wr(8'h04, 4'h3, 32'h0000_07bc);
      event_irq_i = 1'b0;
      resume_detected_i = 1'b0;
      $display("test routing done");
      soft_rst_i = 1'b1;
      @(negedge core_clk_i);
      soft_rst_i = 1'b0;
      rd(8'h04, 32'h0000_03c0);
      downstream_resume_i = 1'b1;
      repeat (3) @(negedge core_clk_i);
      downstream_resume_i = 1'b0;
      chk(32'(functional_state_o), 32'h1);
      for (int s = 0; s < 4; s++) begin
         wr(8'h04, 4'h1, 32'(s) << 6);
         rd(8'h04, 32'h300 | 32'(s) << 6);
      end
      $display("test states done");
      // frame start must wait the programmed delay, not appear at once
      wr(8'h04, 4'h1, 32'h0000_0080);
      k = 0;
      while (sof_enable_o !== 1'b1 && k < 40) begin
         @(negedge core_clk_i);
         k++;
      end
      chk(32'(k >= 18 && k <= 24), 32'h1);
      chk(32'(functional_state_o), 32'h2);
      sys_rst_i = 1'b1;
      repeat (6) @(negedge core_clk_i);
      sys_rst_i = 1'b0;
      rd(8'h04, 32'h0);
      chk(32'({sof_enable_o, functional_state_o}), 32'h0);
      $display("test timing_reset done");
      stop_test;
   end
endmodule // tb_hc_revision_control_regs
`default_nettype wire

// ---- rtl/hc_regs_pkg.sv ----
/*
 * constants for the host controller revision/control register pair:
 * offsets, field positions, reset values, state codes, timing counts.
 * assumes a 32-bit register access port clocked by core_clk_i.
 */
`default_nettype none

package hc_regs_pkg;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] spec_revision_off = 8'h00;
   localparam logic [7:0] controller_control_off = 8'h04;

   // ------------------------------------------------------------------
   // field layout and reset values
   // ------------------------------------------------------------------
   localparam logic [7:0] spec_revision_bcd = 8'h10;   // version 1.0
   localparam int fs_lsb = 6;
   localparam int ple_bit = 2;
   localparam int ie_bit = 3;
   localparam int cle_bit = 4;
   localparam int ble_bit = 5;
   localparam int route_bit = 8;
   localparam int wake_conn_bit = 9;
   localparam int wake_en_bit = 10;
   localparam int cbsr_lsb = 0;
   localparam logic [31:0] control_reset = 32'h0000_0000;

   // ------------------------------------------------------------------
   // functional states, binary coded in order reset, resume, operational, suspend
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      state_reset       = 2'h0,
      state_resume      = 2'h1,
      state_operational = 2'h2,
      state_suspend     = 2'h3
   } func_state_t;

   // ------------------------------------------------------------------
   // timing
   // ------------------------------------------------------------------
   localparam int clk_period_ps = 8000;
   localparam int sof_delay_us = 1000;
   // 1 us is 1e6 ps; the product still fits a 32-bit int
   localparam int sof_delay_cycles =
      (sof_delay_us * 1000000 + clk_period_ps - 1) / clk_period_ps;

endpackage

`default_nettype wire

// ---- rtl/hc_revision_control_regs.sv ----
/*
 * revision and control registers of the full/low-speed host controller.
 * assumes a simple synchronous register port: one-cycle read/write
 * strobes with byte enables, read data registered one cycle later.
 */
`timescale 1ns/1ps
`default_nettype none

module hc_revision_control_regs
   import hc_regs_pkg::*;
#(
   parameter int unsigned sof_delay = sof_delay_cycles
) (
   // clock and resets
   input wire logic core_clk_i,
   input wire logic sys_rst_i,        // hardware reset
   input wire logic soft_rst_i,       // software reset pulse
   // register access port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [3:0] reg_be_i,
   input wire logic [31:0] reg_wdata_i,
   output logic [31:0] reg_rdata_o,
   output logic reg_ack_o,
   // controller events
   input wire logic resume_detected_i,  // resume detected status bit
   input wire logic event_irq_i,        // pending enabled status event
   input wire logic downstream_resume_i,
   // controller outputs
   output logic [1:0] functional_state_o,
   output logic remote_wakeup_o,
   output logic host_irq_o,
   output logic mgmt_irq_o,
   output logic sof_enable_o,
   output logic ple_o,
   output logic ie_o,
   output logic cle_o,
   output logic ble_o,
   output logic [1:0] cbsr_o
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   func_state_t fs_r;
   func_state_t fs_nxt;
   logic [5:0] lists_r;              // cbsr, ple, ie, cle, ble
   logic wake_en_r;
   logic wake_conn_r;
   logic route_r;
   logic wr_ctl;
   logic enter_oper;
   logic sof_go;
   logic [31:0] ctl_view;

   // only the control offset stores writes; revision writes fall away
   assign wr_ctl = reg_wr_i && (reg_addr_i == controller_control_off);

   // full control image; reserved bits are not stored so they read zero
   always_comb begin
      ctl_view = control_reset;
      ctl_view[fs_lsb +: 2] = fs_r;
      ctl_view[5:0] = lists_r;
      ctl_view[route_bit] = route_r;
      ctl_view[wake_conn_bit] = wake_conn_r;
      ctl_view[wake_en_bit] = wake_en_r;
   end

   // ------------------------------------------------------------------
   // functional state
   // ------------------------------------------------------------------
   // next state: driver write, or hardware resume while suspended
   // a driver write to the state byte wins over a downstream resume
   always_comb begin
      fs_nxt = fs_r;
      if (wr_ctl && reg_be_i[0]) begin
         fs_nxt = func_state_t'(reg_wdata_i[fs_lsb +: 2]);
      end else if (fs_r == state_suspend && downstream_resume_i) begin
         fs_nxt = state_resume;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         fs_r <= state_reset;
      end else if (soft_rst_i) begin
         fs_r <= state_suspend;
      end else begin
         fs_r <= fs_nxt;
      end
   end

   // entry edge only, so staying operational never restarts the wait
   assign enter_oper = !sys_rst_i && !soft_rst_i
                       && fs_nxt == state_operational
                       && fs_r != state_operational;

   // ------------------------------------------------------------------
   // driver-owned fields; only writes and resets move them
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || soft_rst_i) begin
         lists_r <= 6'h00;
         wake_en_r <= 1'b0;
      end else if (wr_ctl) begin
         if (reg_be_i[0]) begin
            lists_r <= reg_wdata_i[5:0];
         end
         if (reg_be_i[1]) begin
            wake_en_r <= reg_wdata_i[wake_en_bit];
         end
      end
   end

   // routing and wakeup-connected survive a software reset
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         route_r <= 1'b0;
         wake_conn_r <= 1'b0;
      end else if (wr_ctl && reg_be_i[1]) begin
         route_r <= reg_wdata_i[route_bit];
         wake_conn_r <= reg_wdata_i[wake_conn_bit];
      end
   end

   // ------------------------------------------------------------------
   // start-of-frame delay after entering operational
   // ------------------------------------------------------------------
   sof_delay_timer #(
      .delay_cycles(sof_delay)
   ) u_sof_timer (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(enter_oper),
      .abort_i(fs_nxt != state_operational || soft_rst_i),
      .done_o(sof_go)
   );

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || soft_rst_i || fs_nxt != state_operational) begin
         sof_enable_o <= 1'b0;
      end else if (sof_go) begin
         sof_enable_o <= 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // interrupt routing and remote wakeup
   // ------------------------------------------------------------------
   // wakeup enable is not in the interrupt path at all
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         host_irq_o <= 1'b0;
         mgmt_irq_o <= 1'b0;
         remote_wakeup_o <= 1'b0;
      end else begin
         host_irq_o <= event_irq_i && !route_r;
         mgmt_irq_o <= event_irq_i && route_r;
         remote_wakeup_o <= wake_en_r && resume_detected_i;
      end
   end

   // ------------------------------------------------------------------
   // register outputs and read path
   // ------------------------------------------------------------------
   // registered copies so every output leaves a flip-flop, one cycle late
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         functional_state_o <= state_reset;
         {cbsr_o, ple_o, ie_o, cle_o, ble_o} <= 6'h00;
      end else begin
         functional_state_o <= fs_r;
         cbsr_o <= lists_r[cbsr_lsb +: 2];
         ple_o <= lists_r[ple_bit];
         ie_o <= lists_r[ie_bit];
         cle_o <= lists_r[cle_bit];
         ble_o <= lists_r[ble_bit];
      end
   end

   // unmapped addresses read zero; revision writes are dropped
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 32'h0;
         reg_ack_o <= 1'b0;
      end else begin
         reg_ack_o <= reg_rd_i || reg_wr_i;
         reg_rdata_o <= 32'h0;
         if (reg_rd_i) begin
            unique case (reg_addr_i)
               spec_revision_off:
                  reg_rdata_o <= {24'h0, spec_revision_bcd};
               controller_control_off:
                  reg_rdata_o <= ctl_view;
               default:
                  reg_rdata_o <= 32'h0;
            endcase
         end
      end
   end

endmodule // hc_revision_control_regs

`default_nettype wire

// ---- rtl/sof_delay_timer.sv ----
/*
 * one-shot delay timer: counts a fixed number of cycles after start
 * and then pulses done. assumes one clock, synchronous active-high
 * reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sof_delay_timer #(
   parameter int unsigned delay_cycles = 125000
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   // control
   input wire logic start_i,
   input wire logic abort_i,
   output logic done_o
);

   logic [31:0] count_r;
   logic running_r;

   // ------------------------------------------------------------------
   // counter; abort wins so leaving operational cancels the wait
   // ------------------------------------------------------------------
   always_ff @(posedge core_clk_i) begin
      done_o <= 1'b0;
      if (sys_rst_i || abort_i) begin
         running_r <= 1'b0;
         count_r <= 32'h0;
      end else if (start_i) begin
         running_r <= 1'b1;
         count_r <= 32'h1;
      end else if (running_r) begin
         if (count_r >= 32'(delay_cycles)) begin
            running_r <= 1'b0;
            done_o <= 1'b1;
         end else begin
            count_r <= count_r + 32'h1;
         end
      end
   end

endmodule // sof_delay_timer

`default_nettype wire
